// ### pllsc_top.sv
// Purpose: pll configuration word latch and sleep control
// Assumes: apb slave, inputs synchronous to clk
// Notes: no interrupt logic, single clock
`timescale 1ns/1ps
module pllsc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] nvCfgWord,
  input wire logic [15:0] finKhz,
  input wire logic waitInstr,
  input wire logic irqPending,
  input wire logic periphWake,
  input wire logic usbKeepOsc,
  input wire logic brownoutDetect,
  input wire logic wdogTick,
  input wire logic [31:0] pinDriveIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpuRun,
  output logic fetchEnable,
  output logic sysClkEnable,
  output logic periphClkEnable,
  output logic sleepDomainEnable,
  output logic oscPrimaryEnable,
  output logic oscFastRcEnable,
  output logic clockMonitorActive,
  output logic brownoutResetReq,
  output logic usbPllBypass,
  output logic [31:0] pinDriveOut
);
  pllsc_cfg_if cfg ();
  pllsc_pkg::pllsc_state_e stateReg, stateNext;
  logic [31:0] cfgWordReg;
  logic [31:0] ctrlReg;
  logic [15:0] wdogReg;
  logic [7:0] cntReg;
  logic [7:0] wakeDly;
  logic [31:0] sysKhz;
  logic [31:0] rdata;
  logic apbWr;
  logic apbRd;
  logic wakeEvent;
  logic asleep;
  logic osc;
  logic [1:0] oscSel;

  // ==========================================================
  // latched pll fields feed decoder and frequency calc
  assign cfg.outCode = cfgWordReg[pllsc_pkg::POS_ODIV +: 3];
  assign cfg.mulCode = cfgWordReg[pllsc_pkg::POS_MUL +: 3];
  assign cfg.inCode = cfgWordReg[pllsc_pkg::POS_IDIV +: 3];
  assign cfg.usbInCode = cfgWordReg[pllsc_pkg::POS_UDIV +: 3];

  pllsc_decode uDec (
    .cfg(cfg)
  );

  pllsc_freq uFreq (
    .clk(clk),
    .rst_n(rst_n),
    .finKhz(finKhz),
    .cfg(cfg),
    .sysKhz(sysKhz)
  );

  // ==========================================================
  // apb decode, zero wait state
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign oscSel = ctrlReg[pllsc_pkg::POS_OSC_SEL +: 2];
  assign asleep = (stateReg == pllsc_pkg::ST_SLEEP);
  assign osc = 1'b0;
  assign wakeEvent = irqPending || periphWake;

  // configuration word captured once per reset, during reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWordReg <= pllsc_pkg::CFG_ERASED;
    end else if (stateReg == pllsc_pkg::ST_RELOAD && cntReg == 8'h0) begin
      cfgWordReg <= nvCfgWord;
    end
  end

  // control register: monitor enables and oscillator select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= pllsc_pkg::CTRL_RESET;
    end else if (apbWr && paddr == pllsc_pkg::ADDR_CTRL) begin
      ctrlReg <= {26'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
    end
  end

  // ==========================================================
  // wake delay chosen by oscillator in use
  always_comb begin
    case (oscSel)
      pllsc_pkg::OSC_PRIMARY: wakeDly = pllsc_pkg::WAKE_DLY_PRIMARY_OSCILLATOR;
      pllsc_pkg::OSC_FAST_RC: wakeDly = pllsc_pkg::WAKE_DLY_FRC;
      pllsc_pkg::OSC_LOW_POWER_RC: wakeDly = pllsc_pkg::WAKE_DLY_LOW_POWER_RC_OSCILLATOR;
      default: wakeDly = pllsc_pkg::WAKE_DLY_EXT;
    endcase
  end

  // power state sequencing
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      pllsc_pkg::ST_RELOAD: begin
        if (cntReg == 8'(pllsc_pkg::FUSE_DELAY_CYC - 1)) begin
          stateNext = pllsc_pkg::ST_FETCHWAIT;
        end
      end
      pllsc_pkg::ST_FETCHWAIT: begin
        if (cntReg == 8'(pllsc_pkg::SYSTEM_CLOCK_DELAY_CYC - 1)) begin
          stateNext = pllsc_pkg::ST_RUN;
        end
      end
      pllsc_pkg::ST_RUN: begin
        if (waitInstr && !wakeEvent) begin
          stateNext = pllsc_pkg::ST_SLEEP;
        end
      end
      pllsc_pkg::ST_SLEEP: begin
        if (wakeEvent) begin
          stateNext = pllsc_pkg::ST_WAKE;
        end
      end
      pllsc_pkg::ST_WAKE: begin
        if (cntReg >= wakeDly - 8'h1) begin
          stateNext = pllsc_pkg::ST_RUN;
        end
      end
      default: stateNext = pllsc_pkg::ST_RELOAD;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= pllsc_pkg::ST_RELOAD;
    end else begin
      stateReg <= stateNext;
    end
  end

  // phase counter, restarts on every state change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntReg <= 8'h0;
    end else if (stateNext != stateReg) begin
      cntReg <= 8'h0;
    end else if (cntReg != 8'hff) begin
      cntReg <= cntReg + 8'h1;
    end
  end

  // ==========================================================
  // watchdog counter keeps counting, never cleared by sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdogReg <= 16'h0;
    end else if (apbWr && paddr == pllsc_pkg::ADDR_WDOG) begin
      wdogReg <= 16'h0;
    end else if (ctrlReg[pllsc_pkg::POS_WDT_EN] && wdogTick) begin
      wdogReg <= wdogReg + 16'h1;
    end
  end

  // clock, domain and oscillator gating outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuRun <= 1'b0;
      fetchEnable <= 1'b0;
      sysClkEnable <= 1'b0;
      periphClkEnable <= 1'b0;
      sleepDomainEnable <= 1'b0;
      oscPrimaryEnable <= 1'b0;
      oscFastRcEnable <= 1'b0;
      clockMonitorActive <= 1'b0;
    end else begin
      cpuRun <= (stateNext == pllsc_pkg::ST_RUN);
      fetchEnable <= (stateNext == pllsc_pkg::ST_RUN);
      sysClkEnable <= (stateNext != pllsc_pkg::ST_SLEEP);
      periphClkEnable <= (stateNext == pllsc_pkg::ST_RUN);
      sleepDomainEnable <= (stateNext != pllsc_pkg::ST_RELOAD);
      // usb keep-alive holds both usb-capable sources, whatever cpu uses
      oscPrimaryEnable <= (stateNext != pllsc_pkg::ST_SLEEP) ||
        usbKeepOsc;
      oscFastRcEnable <= (stateNext != pllsc_pkg::ST_SLEEP) ||
        usbKeepOsc;
      clockMonitorActive <= ctrlReg[pllsc_pkg::POS_CFM_EN] &&
        (stateNext == pllsc_pkg::ST_RUN);
    end
  end

  // brownout reset request, active in every state when enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownoutResetReq <= 1'b0;
    end else begin
      brownoutResetReq <= ctrlReg[pllsc_pkg::POS_BOR_EN] &&
        brownoutDetect;
    end
  end

  // pin drive passes through regardless of sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinDriveOut <= 32'h0;
      usbPllBypass <= 1'b1;
    end else begin
      pinDriveOut <= pinDriveIn;
      usbPllBypass <= cfgWordReg[pllsc_pkg::POS_UPLLDIS];
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    case (paddr)
      pllsc_pkg::ADDR_CFG: rdata = cfgWordReg;
      pllsc_pkg::ADDR_CTRL: rdata = ctrlReg;
      pllsc_pkg::ADDR_STAT: rdata = {25'h0, asleep, osc, usbPllBypass,
        1'b0, stateReg};
      pllsc_pkg::ADDR_FREQ: rdata = sysKhz;
      pllsc_pkg::ADDR_WDOG: rdata = {16'h0, wdogReg};
      pllsc_pkg::ADDR_WAKE: rdata = {24'h0, wakeDly};
      default: rdata = 32'h0;
    endcase
  end

  // apb answer: data in access phase, error on unmapped address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > pllsc_pkg::ADDR_WAKE ||
        paddr[1:0] != 2'h0);
      if (apbRd) begin
        prdata <= rdata;
      end
    end
  end
endmodule : pllsc_top

// ### pllsc_pkg.sv
// Purpose: constants for the pll configuration and sleep control block
// Assumes: 10 MHz clock, apb register access
package pllsc_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_FREQ = 12'h00c;
  localparam logic [11:0] ADDR_WDOG = 12'h010;
  localparam logic [11:0] ADDR_WAKE = 12'h014;
  // ==========================================================
  // configuration word fields
  localparam int POS_ODIV = 16;
  localparam int POS_UPLLDIS = 15;
  localparam int POS_UDIV = 8;
  localparam int POS_MUL = 4;
  localparam int POS_IDIV = 0;
  localparam logic [31:0] RESERVED_MASK = 32'hfff8_7888;
  localparam logic [31:0] CFG_ERASED = 32'hffff_ffff;
  // ==========================================================
  // control register fields
  localparam int POS_BOR_EN = 0;
  localparam int POS_WDT_EN = 1;
  localparam int POS_CFM_EN = 2;
  localparam int POS_OSC_SEL = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FUSE_DELAY_NS = 1000;
  localparam int FUSE_DELAY_CYC = (FUSE_DELAY_NS * (CLK_HZ / 1_000_000)
    + 999) / 1000;
  localparam int SYSTEM_CLOCK_DELAY_CYC = 8;
  localparam int FETCH_DELAY_CYC = FUSE_DELAY_CYC + SYSTEM_CLOCK_DELAY_CYC;
  localparam logic [7:0] WAKE_DLY_PRIMARY_OSCILLATOR = 8'h40;
  localparam logic [7:0] WAKE_DLY_FRC = 8'h08;
  localparam logic [7:0] WAKE_DLY_LOW_POWER_RC_OSCILLATOR = 8'h02;
  localparam logic [7:0] WAKE_DLY_EXT = 8'h01;
  // ==========================================================
  // oscillator selection codes
  typedef enum logic [1:0] {
    OSC_PRIMARY = 2'h0,
    OSC_FAST_RC = 2'h1,
    OSC_LOW_POWER_RC = 2'h2,
    OSC_EXTERNAL = 2'h3
  } pllsc_osc_e;
  // ==========================================================
  // power state, gray coded along reset->run->sleep->wake
  typedef enum logic [2:0] {
    ST_RELOAD = 3'b000,
    ST_FETCHWAIT = 3'b001,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b110
  } pllsc_state_e;
endpackage : pllsc_pkg

// ### pllsc_cfg_if.sv
// Purpose: carries latched pll settings between modules
// Assumes: single clock
// Notes: decoder side drives the factors
`timescale 1ns/1ps
interface pllsc_cfg_if;
  logic [2:0] outCode;
  logic [2:0] mulCode;
  logic [2:0] inCode;
  logic [2:0] usbInCode;
  logic [8:0] postDiv;
  logic [4:0] mulFactor;
  logic [3:0] inDiv;
  logic [3:0] usbInDiv;
  modport src (output outCode, mulCode, inCode, usbInCode,
    input postDiv, mulFactor, inDiv, usbInDiv);
  modport dec (input outCode, mulCode, inCode, usbInCode,
    output postDiv, mulFactor, inDiv, usbInDiv);
endinterface : pllsc_cfg_if

// ### pllsc_decode.sv
// Purpose: turns pll field codes into numeric factors
// Assumes: codes stable after reset reload
// Notes: pure combinational
`timescale 1ns/1ps
module pllsc_decode (
  pllsc_cfg_if.dec cfg
);
  // ==========================================================
  // input divider table shared by both plls
  function automatic logic [3:0] inDivOf(input logic [2:0] c);
    case (c)
      3'h6: inDivOf = 4'ha;
      3'h7: inDivOf = 4'hc;
      default: inDivOf = {1'b0, c} + 4'h1;
    endcase
  endfunction : inDivOf

  // postscaler: powers of two, top code jumps to 256
  always_comb begin
    if (cfg.outCode == 3'h7) begin
      cfg.postDiv = 9'h100;
    end else begin
      cfg.postDiv = 9'h001 << cfg.outCode;
    end
  end

  // multiplier: 15 plus code, code seven is 24
  always_comb begin
    if (cfg.mulCode == 3'h7) begin
      cfg.mulFactor = 5'h18;
    end else begin
      cfg.mulFactor = 5'h0f + {2'h0, cfg.mulCode};
    end
  end

  // input dividers
  assign cfg.inDiv = inDivOf(cfg.inCode);
  assign cfg.usbInDiv = inDivOf(cfg.usbInCode);
endmodule : pllsc_decode

// ### pllsc_freq.sv
// Purpose: computes system clock frequency from pll factors
// Assumes: input frequency in kHz
// Notes: result registered for timing
`timescale 1ns/1ps
module pllsc_freq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] finKhz,
  pllsc_cfg_if.src cfg,
  output logic [31:0] sysKhz
);
  logic [31:0] prod;
  logic [31:0] quot;
  logic [31:0] sysKhzReg;

  // fin * mul / (div * post)
  always_comb begin
    prod = 32'({16'h0, finKhz} * {27'h0, cfg.mulFactor});
    quot = prod / (32'({28'h0, cfg.inDiv}) * 32'({23'h0, cfg.postDiv}));
  end

  // registered result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysKhzReg <= 32'h0;
    end else begin
      sysKhzReg <= quot;
    end
  end
  assign sysKhz = sysKhzReg;
  // codes are driven by the top through the same interface
endmodule : pllsc_freq

// ### pllsc_chk.sv
// Purpose: port checks for pll config and sleep control
// Assumes: one clock, async active low reset
// Notes: bound to pllsc_top below the module
`timescale 1ns/1ps
module pllsc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic waitInstr,
  input wire logic irqPending,
  input wire logic periphWake,
  input wire logic usbKeepOsc,
  input wire logic brownoutDetect,
  input wire logic [31:0] pinDriveIn,
  input wire logic cpuRun,
  input wire logic fetchEnable,
  input wire logic sleepDomainEnable,
  input wire logic oscPrimaryEnable,
  input wire logic oscFastRcEnable,
  input wire logic clockMonitorActive,
  input wire logic brownoutResetReq,
  input wire logic [31:0] pinDriveOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // edges since reset release, saturating
  logic [5:0] rstCnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstCnt <= 6'h00;
    else if (rstCnt != 6'h3f) rstCnt <= rstCnt + 6'h01;
  end
  // ==========================================================
  // sleep entry request
  sequence sEnter;
    cpuRun && waitInstr && !irqPending && !periphWake;
  endsequence
  a_fetch_hold: assert property (
    rstCnt < pllsc_pkg::FETCH_DELAY_CYC |-> !fetchEnable && !cpuRun)
    else $error("fetch before reset delay");
  a_fetch_start: assert property (
    rstCnt == pllsc_pkg::FETCH_DELAY_CYC |-> fetchEnable && cpuRun)
    else $error("fetch late after reset");
  a_sleep_halt: assert property (
    sEnter |=> !cpuRun && !fetchEnable && !clockMonitorActive)
    else $error("cpu or monitor running asleep");
  a_sleep_keep: assert property (
    sEnter |=> sleepDomainEnable)
    else $error("sleep domain stopped");
  a_usb_osc: assert property (
    sEnter ##0 usbKeepOsc |=> oscPrimaryEnable && oscFastRcEnable)
    else $error("oscillator dropped despite usb");
  a_wake_time: assert property (
    rstCnt > pllsc_pkg::FETCH_DELAY_CYC && !cpuRun
      && (irqPending || periphWake) |-> ##[1:80] cpuRun)
    else $error("no wake after request");
  a_sleep_cause: assert property (
    $fell(cpuRun) |-> $past(waitInstr))
    else $error("cpu halted without wait");
  a_pin_follow: assert property (
    rstCnt != 6'h00 |-> pinDriveOut == $past(pinDriveIn))
    else $error("pin drive not kept");
  a_bor_cause: assert property (
    $rose(brownoutResetReq) |-> $past(brownoutDetect)
      || $past(brownoutDetect, 2))
    else $error("brownout request without cause");
endmodule : pllsc_chk

bind pllsc_top pllsc_chk uChk (.clk, .rst_n, .waitInstr, .irqPending,
  .periphWake, .usbKeepOsc, .brownoutDetect, .pinDriveIn, .cpuRun,
  .fetchEnable, .sleepDomainEnable, .oscPrimaryEnable, .oscFastRcEnable,
  .clockMonitorActive, .brownoutResetReq, .pinDriveOut);

// ### pllsc_top_tb.sv
// Purpose: directed bench for pll config and sleep control
// Assumes: 10 MHz clock, bench is the apb master
// Notes: wake delays compared against the external source
`timescale 1ns/1ps
module pllsc_top_tb;
  // ==========================================================
  // signals
  logic clk, rst_n = 1'b0, waitInstr = 1'b0, irqPending = 1'b0;
  logic periphWake = 1'b0, usbKeepOsc = 1'b0, brownoutDetect = 1'b0;
  logic wdogTick = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] nvCfgWord = 32'hffff_ffff, pinDriveIn = 32'h0;
  logic [31:0] pwdata = 32'h0, prdata, pinDriveOut, cfg, rdat;
  logic [15:0] finKhz = 16'h3c00;
  logic [11:0] paddr = 12'h000;
  logic pready, pslverr, cpuRun, fetchEnable, sysClkEnable, rerr;
  logic periphClkEnable, sleepDomainEnable, oscPrimaryEnable;
  logic oscFastRcEnable, clockMonitorActive, brownoutResetReq;
  logic usbPllBypass;
  int nErrors = 0, nChecks = 0, cyc = 0, n, lat[4];
  int dv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int ml[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  int ps[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  int dly[4] = '{pllsc_pkg::WAKE_DLY_PRIMARY_OSCILLATOR, pllsc_pkg::WAKE_DLY_FRC,
    pllsc_pkg::WAKE_DLY_LOW_POWER_RC_OSCILLATOR, pllsc_pkg::WAKE_DLY_EXT};

  pllsc_top dut (.clk, .rst_n, .nvCfgWord, .finKhz, .waitInstr, .irqPending,
    .periphWake, .usbKeepOsc, .brownoutDetect, .wdogTick, .pinDriveIn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpuRun,
    .fetchEnable, .sysClkEnable, .periphClkEnable, .sleepDomainEnable,
    .oscPrimaryEnable, .oscFastRcEnable, .clockMonitorActive,
    .brownoutResetReq, .usbPllBypass, .pinDriveOut);

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tallyAndFinish;
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tallyAndFinish

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdChk(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rdChk

  task automatic pulse(input int t);
    repeat (t) begin
      @(posedge clk) wdogTick <= 1'b1;
      @(posedge clk) wdogTick <= 1'b0;
    end
  endtask : pulse

  task automatic doRst(input logic [31:0] c);
    int k = 0;
    nvCfgWord <= c;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (fetchEnable !== 1'b1 && k < 100);
    chk("fetch delay", pllsc_pkg::FETCH_DELAY_CYC + 1, k);
  endtask : doRst

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      nErrors++;
      tallyAndFinish();
    end
  end

  // main sequence
  initial begin
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      cfg = (i * 32'h10111) | (i % 2 * 32'h8000);
      cfg = cfg | pllsc_pkg::RESERVED_MASK;
      doRst(cfg);
      nvCfgWord <= ~cfg;
      rdChk("cfg word", pllsc_pkg::ADDR_CFG, cfg);
      n = finKhz / dv[i] * ml[i] / ps[i];
      rdChk("system_clock", pllsc_pkg::ADDR_FREQ, n);
      chk("usb bypass", i % 2, usbPllBypass);
    end
    $display("test cfg done");
    rdChk("ctrl reset", pllsc_pkg::ADDR_CTRL, pllsc_pkg::CTRL_RESET);
    apb(1'b1, pllsc_pkg::ADDR_CFG, 32'h0);
    rdChk("cfg read only", pllsc_pkg::ADDR_CFG, cfg);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, rerr);
    $display("test regs done");
    for (int o = 0; o < 4; o++) begin
      apb(1'b1, pllsc_pkg::ADDR_CTRL, 32'h7 | (o << 4));
      apb(1'b1, pllsc_pkg::ADDR_WDOG, 32'h0);
      usbKeepOsc <= (o < 2);
      pulse(5);
      @(posedge clk) waitInstr <= 1'b1;
      @(posedge clk) waitInstr <= 1'b0;
      @(posedge clk);
      chk("cpu halted", 32'h0, cpuRun);
      chk("monitor off", 32'h0, clockMonitorActive);
      pulse(3);
      brownoutDetect <= 1'b1;
      pinDriveIn <= 32'h5a5a_0000 | o;
      repeat (3) @(posedge clk);
      chk("brownout req", 32'h1, brownoutResetReq);
      chk("still asleep", 32'h0, cpuRun);
      chk("system_clock off", 32'h0, sysClkEnable);
      chk("periph clk off", 32'h0, periphClkEnable);
      chk("sleep domain on", 32'h1, sleepDomainEnable);
      chk("primary_oscillator kept", o < 2, oscPrimaryEnable);
      chk("frc kept", o < 2, oscFastRcEnable);
      chk("pins driven", 32'h5a5a_0000 | o, pinDriveOut);
      brownoutDetect <= 1'b0;
      if (o % 2) periphWake <= 1'b1;
      else irqPending <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cpuRun !== 1'b1 && n < 200);
      lat[o] = n;
      chk("monitor on", 32'h1, clockMonitorActive);
      irqPending <= 1'b0;
      periphWake <= 1'b0;
      rdChk("wdog count", pllsc_pkg::ADDR_WDOG, 32'h8);
    end
    for (int o = 0; o < 4; o++) begin
      chk("wake delay", dly[o] - dly[3], lat[o] - lat[3]);
    end
    $display("test sleep done");
    tallyAndFinish();
  end
endmodule : pllsc_top_tb
